// [common/ldc_pkg.sv]
// Package for the loop and transition-offset configuration registers.
// Assumes a byte-wide register port decoded from the host serial interface.
package ldc_pkg;

    // ==========================================
    // Register addresses
    localparam logic [7:0] ADDR_LOOP_TUNING_THREE = 8'hAD;
    localparam logic [7:0] ADDR_FAST_SLEW_SELECT = 8'hAF;
    localparam logic [7:0] ADDR_TRANSITION_OFFSET = 8'hB0;
    localparam logic [7:0] ADDR_FAST_SLEW_MIRROR = 8'h24;

    // ==========================================
    // Writable field masks
    localparam logic [7:0] MASK_LOOP = 8'h7F;
    localparam logic [7:0] MASK_SLEW = 8'h07;
    localparam logic [7:0] MASK_OFFSET = 8'h0F;

    // ==========================================
    // Field positions
    localparam int POS_SS_FORCE = 6;
    localparam int POS_NOC_TON = 5;
    localparam int POS_IND_LSB = 3;
    localparam int POS_DC_LOAD_LINE_LSB = 0;
    localparam int POS_FALL_LSB = 2;
    localparam int POS_RISE_LSB = 0;

    // ==========================================
    // Constants in millivolts (on-time numerators) and the quarter-rate divider
    localparam logic [11:0] NOC_SHORT_5MV = 12'h258;
    localparam logic [11:0] NOC_LONG_5MV = 12'h640;
    localparam logic [11:0] NOC_SHORT_10MV = 12'h4B0;
    localparam logic [11:0] NOC_LONG_10MV = 12'hC80;
    localparam logic [7:0] SLOW_DIVIDE = 8'h04;

    // Transition rate choices from the voltage-ID side
    typedef enum logic [1:0] {
        RATE_FAST = 2'b00,
        RATE_SLOW = 2'b01,
        RATE_DECAY = 2'b10,
        RATE_NONE = 2'b11
    } ldc_rate_e;

    typedef struct packed {
        logic softStartLightLoadForce;
        logic negCurrentOnTimeSelect;
        logic [1:0] senseInductanceSelect;
        logic [2:0] dcLoadLine;
    } ldc_loop_s;

    typedef struct packed {
        logic [1:0] fallOffset;
        logic [1:0] riseOffset;
    } ldc_offset_s;

endpackage

// [hw/ldc_config_regs.sv]
// Loop tuning, fast slew select and transition-offset registers, plus the
// DAC offset sequencer that uses them during dynamic voltage changes.
// Assumes an upstream serial decoder supplies byte writes and reads.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Reserved loop bit 7 and slew bits 7:3 always read zero.
// - Loop bit 6 forces discontinuous soft-start, else follows forced-continuous setting.
// - Loop bit 5 set picks shorter negative-current on-time, clear picks longer.
// - On-time numerator 0.6/1.6 V for 5 mV steps, 1.2/3.2 V for 10 mV.
// - Loop bits 4:3 select sensed inductance 100 to 400 nH.
// - Loop bits 2:0 select DC load line; code zero means flat regulation.
// - Slew select sets fast-command rate, never turn-on or turn-off ramps.
// - Acknowledged slew write is copied to mirror register 24h on the next cycle.
// - Slew codes map 1.34 to 12.50 mV/us for 5 mV steps.
// - Slew codes map 2.67 to 25.00 mV/us for 10 mV steps.
// - Transition offsets apply only during a dynamic voltage transition.
// - Offsets apply only when fast or slow transition rate is selected.
// - No offsets for decay transitions or serial output voltage writes.
// - No offsets during soft-start or soft-stop ramps.
// - Rise offset added on first up step, dropped when target reached.
// - Down: full rate until target plus fall offset, then quarter rate.
module ldc_config_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic writeAck,
    output logic [7:0] regReadData,
    // Backup load of reset values
    input wire logic backupLoad,
    input wire logic [7:0] backupLoop,
    input wire logic [7:0] backupSlew,
    input wire logic [7:0] backupOffset,
    // System context
    input wire logic [1:0] vidStepProtocol,
    input wire logic forcedContinuousOperation,
    input wire logic softStartActive,
    input wire logic softStopActive,
    input wire logic serialVoutChange,
    // Voltage transition control
    input wire logic transitionStart,
    input wire ldc_pkg::ldc_rate_e transitionRate,
    input wire logic [7:0] targetCode,
    input wire logic [7:0] currentCode,
    input wire logic stepTick,
    // Loop settings out
    output logic softStartDiscontinuous,
    output logic [11:0] negOnTimeNumeratorMv,
    output logic [1:0] senseInductanceSelect,
    output logic [2:0] dcLoadLine,
    // Voltage interface mirror
    output logic fastSlewMirrorWrite,
    output logic [7:0] fastSlewMirrorAddr,
    output logic [2:0] fastSlewMirror,
    output logic slewIs10mvTable,
    // DAC offset sequencing
    output logic [7:0] dacOffsetCode,
    output logic quarterRate,
    output logic transitionActive
);

    // ==========================================
    // Register storage
    localparam int NUM_ENTRIES = 3;
    // Entry 0 loop tuning, 1 fast slew select, 2 transition offset
    localparam logic [7:0] ENTRY_ADDR [NUM_ENTRIES] = '{
        ldc_pkg::ADDR_LOOP_TUNING_THREE,
        ldc_pkg::ADDR_FAST_SLEW_SELECT,
        ldc_pkg::ADDR_TRANSITION_OFFSET
    };
    localparam logic [7:0] ENTRY_MASK [NUM_ENTRIES] = '{
        ldc_pkg::MASK_LOOP,
        ldc_pkg::MASK_SLEW,
        ldc_pkg::MASK_OFFSET
    };
    logic [7:0] loopReg;
    logic [7:0] slewReg;
    logic [7:0] offsetReg;
    ldc_pkg::ldc_loop_s loopFields;
    ldc_pkg::ldc_offset_s offFields;
    wire logic [NUM_ENTRIES-1:0][7:0] entryBackup = {backupOffset, backupSlew, backupLoop};
    wire logic [NUM_ENTRIES-1:0][7:0] entryRead;

    // ==========================================
    // One storage entry per mapped address
    for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_entry
        logic [7:0] value;
        wire logic hit = regAddr == ENTRY_ADDR[e];
        wire logic accept = regWrite && writeAck && hit;
        // Masking on every load keeps reserved bits at zero
        always_ff @(posedge clk) begin
            if (reset) begin
                value <= 8'h00;
            end else if (backupLoad) begin
                value <= entryBackup[e] & ENTRY_MASK[e];
            end else if (accept) begin
                value <= regWriteData & ENTRY_MASK[e];
            end
        end
        // Unselected entries show zero so the read is a plain OR
        assign entryRead[e] = hit ? value : 8'h00;
    end

    assign loopReg = g_entry[0].value;
    assign slewReg = g_entry[1].value;
    assign offsetReg = g_entry[2].value;
    wire logic wrSlew = g_entry[1].accept;

    // Reads of unmapped addresses return zero
    assign regReadData = entryRead[0] | entryRead[1] | entryRead[2];

    assign loopFields = ldc_pkg::ldc_loop_s'(loopReg[6:0]);
    assign offFields = ldc_pkg::ldc_offset_s'(offsetReg[3:0]);

    // ==========================================
    // Loop settings
    wire logic stepIs10mv = (vidStepProtocol == 2'b00) || (vidStepProtocol == 2'b11);
    // Light-load mode during soft-start only; after the ramp the caller ignores it
    wire logic next_softStartDiscontinuous = loopFields.softStartLightLoadForce || !forcedContinuousOperation;
    wire logic [11:0] shortNum = stepIs10mv ? ldc_pkg::NOC_SHORT_10MV : ldc_pkg::NOC_SHORT_5MV;
    wire logic [11:0] longNum = stepIs10mv ? ldc_pkg::NOC_LONG_10MV : ldc_pkg::NOC_LONG_5MV;
    wire logic [11:0] next_negOnTimeNumeratorMv = loopFields.negCurrentOnTimeSelect ? shortNum : longNum;

    // Registered so the loop sees clean levels, one cycle after a change
    always_ff @(posedge clk) begin
        if (reset) begin
            softStartDiscontinuous <= 1'b0;
            negOnTimeNumeratorMv <= 12'h000;
        end else begin
            softStartDiscontinuous <= next_softStartDiscontinuous;
            negOnTimeNumeratorMv <= next_negOnTimeNumeratorMv;
        end
    end
    assign senseInductanceSelect = loopFields.senseInductanceSelect;
    assign dcLoadLine = loopFields.dcLoadLine;

    // ==========================================
    // Fast slew mirror; rate table chosen downstream by step size
    always_ff @(posedge clk) begin
        if (reset) begin
            fastSlewMirrorWrite <= 1'b0;
            slewIs10mvTable <= 1'b0;
        end else begin
            fastSlewMirrorWrite <= wrSlew || backupLoad;
            slewIs10mvTable <= stepIs10mv;
        end
    end
    assign fastSlewMirrorAddr = ldc_pkg::ADDR_FAST_SLEW_MIRROR;
    assign fastSlewMirror = slewReg[2:0];

    // ==========================================
    // Offset sequencing
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_UP = 2'b01,
        SEQ_DOWN = 2'b10
    } ldc_seq_e;

    ldc_seq_e seqState;
    ldc_seq_e next_seqState;
    logic [7:0] riseCode;
    logic [7:0] fallCode;
    logic [7:0] seqTarget;

    // Offset in DAC codes; a part step on the 10 mV table rounds up
    function automatic logic [7:0] offsetCodes(input logic [1:0] sel, input logic tenMv);
        logic [7:0] codes;
        codes = 8'h00;
        unique case ({tenMv, sel})
            3'b000: codes = 8'h00;
            3'b001: codes = 8'h01;
            3'b010: codes = 8'h02;
            3'b011: codes = 8'h04;
            3'b100: codes = 8'h00;
            3'b101: codes = 8'h01;
            3'b110: codes = 8'h01;
            3'b111: codes = 8'h02;
        endcase
        offsetCodes = codes;
    endfunction

    assign riseCode = offsetCodes(offFields.riseOffset, stepIs10mv);
    assign fallCode = offsetCodes(offFields.fallOffset, stepIs10mv);

    wire logic rampBlocked = softStartActive || softStopActive || serialVoutChange;
    wire logic rateOk = transitionRate == ldc_pkg::RATE_FAST || transitionRate == ldc_pkg::RATE_SLOW;
    wire logic canOffset = transitionStart && rateOk && !rampBlocked;
    wire logic reached = currentCode == seqTarget;
    wire logic [8:0] fallLimit = {1'b0, seqTarget} + {1'b0, fallCode};

    always_comb begin
        next_seqState = seqState;
        unique case (seqState)
            SEQ_IDLE: begin
                if (canOffset && targetCode > currentCode) begin
                    next_seqState = SEQ_UP;
                end else if (canOffset && targetCode < currentCode) begin
                    next_seqState = SEQ_DOWN;
                end
            end
            SEQ_UP: begin
                if (reached || rampBlocked) begin
                    next_seqState = SEQ_IDLE;
                end
            end
            SEQ_DOWN: begin
                if (reached || rampBlocked) begin
                    next_seqState = SEQ_IDLE;
                end
            end
            default: next_seqState = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            seqState <= SEQ_IDLE;
            seqTarget <= 8'h00;
        end else begin
            seqState <= next_seqState;
            if (seqState == SEQ_IDLE && canOffset) begin
                seqTarget <= targetCode;
            end
        end
    end

    assign transitionActive = seqState != SEQ_IDLE;
    // Rise offset held from the first step until the target is hit
    wire logic upOffsetOn = seqState == SEQ_UP && !reached && !rampBlocked;
    wire logic quarterOn = seqState == SEQ_DOWN && !rampBlocked && {1'b0, currentCode} <= fallLimit;

    // A blocking ramp clears both outputs at the edge that aborts the sequence
    always_ff @(posedge clk) begin
        if (reset) begin
            dacOffsetCode <= 8'h00;
            quarterRate <= 1'b0;
        end else begin
            dacOffsetCode <= upOffsetOn ? riseCode : 8'h00;
            quarterRate <= quarterOn;
        end
    end

    wire logic unusedTick = stepTick;

endmodule

`default_nettype wire

// [sim/ldc_config_regs_sva.sv]
// Port checker for the loop and transition-offset registers.
// Assumes binding onto ldc_config_regs.
`timescale 1ns/100ps
`default_nettype none
module ldc_config_regs_sva (
    // Clock, reset, register port, backup load, mirror address and DAC offset
    input wire logic clk, reset, regWrite, writeAck, backupLoad,
    input wire logic [7:0] regAddr, regWriteData, regReadData, fastSlewMirrorAddr, dacOffsetCode,
    // Context and results
    input wire logic forcedContinuousOperation, softStartActive, softStopActive, transitionStart,
    input wire logic [1:0] vidStepProtocol, senseInductanceSelect,
    input wire ldc_pkg::ldc_rate_e transitionRate,
    input wire logic softStartDiscontinuous, fastSlewMirrorWrite, quarterRate, transitionActive, slewIs10mvTable,
    input wire logic [11:0] negOnTimeNumeratorMv,
    input wire logic [2:0] dcLoadLine, fastSlewMirror
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire tenMv = (vidStepProtocol == 2'h0) || (vidStepProtocol == 2'h3);
    sequence s_slewWrite; regWrite && writeAck && regAddr == 8'hAF && !backupLoad; endsequence
    // Two cycles so a registered offset may clear first
    sequence s_ramp; (softStartActive || softStopActive)[*2]; endsequence
    property p_loopRsvd; regAddr == 8'hAD |-> regReadData[7] == 1'b0; endproperty
    property p_slewRsvd; regAddr == 8'hAF |-> regReadData[7:3] == 5'h00; endproperty
    property p_mirror; s_slewWrite |=> fastSlewMirrorWrite && fastSlewMirror == $past(regWriteData[2:0]); endproperty
    property p_mirrorAddr; fastSlewMirrorWrite |-> fastSlewMirrorAddr == 8'h24; endproperty
    property p_softStart;
        regAddr == 8'hAD |=> softStartDiscontinuous == ($past(regReadData[6]) || !$past(forcedContinuousOperation));
    endproperty
    property p_onTime;
        regAddr == 8'hAD |=> negOnTimeNumeratorMv ==
            ($past(regReadData[5]) ? ($past(tenMv) ? 12'h4B0 : 12'h258) : ($past(tenMv) ? 12'hC80 : 12'h640));
    endproperty
    property p_tableSel; 1'b1 |=> slewIs10mvTable == $past(tenMv); endproperty
    property p_noOffsetIdle; !transitionActive |=> dacOffsetCode == 8'h00 && !quarterRate; endproperty
    property p_fields; regAddr == 8'hAD |-> {senseInductanceSelect, dcLoadLine} == regReadData[4:0]; endproperty
    property p_ramp; s_ramp |-> dacOffsetCode == 8'h00 && !quarterRate; endproperty
    property p_decay;
        transitionStart && transitionRate == ldc_pkg::RATE_DECAY && !transitionActive |=> !transitionActive;
    endproperty
    a_loopRsvd: assert property (p_loopRsvd) else $error("loop reserved bit set");
    a_slewRsvd: assert property (p_slewRsvd) else $error("slew reserved bits set");
    a_mirror: assert property (p_mirror) else $error("mirror copy wrong");
    a_mirrorAddr: assert property (p_mirrorAddr) else $error("mirror index wrong");
    a_softStart: assert property (p_softStart) else $error("soft-start mode wrong");
    a_onTime: assert property (p_onTime) else $error("on-time numerator wrong");
    a_fields: assert property (p_fields) else $error("loop fields wrong");
    a_ramp: assert property (p_ramp) else $error("offset during ramp");
    a_decay: assert property (p_decay) else $error("decay started transition");
    a_tableSel: assert property (p_tableSel) else $error("slew table select wrong");
    a_noOffsetIdle: assert property (p_noOffsetIdle) else $error("offset outside transition");
endmodule
bind ldc_config_regs ldc_config_regs_sva u_ldc_config_regs_sva (.*);
`default_nettype wire

// [sim/ldc_vid_mirror.sv]
// Far-side model: voltage-interface fast slew register.
// Assumes it shares the register block's clock.
`timescale 1ns/100ps
`default_nettype none
module ldc_vid_mirror (
    // Clock
    input wire logic clk,
    // Mirror port
    input wire logic mirrorWrite,
    input wire logic [7:0] mirrorAddr,
    input wire logic [2:0] mirrorData,
    output logic [2:0] fastSlew
);
    initial fastSlew = 3'h0;
    always @(posedge clk) begin
        if (mirrorWrite && mirrorAddr == 8'h24) begin
            fastSlew <= mirrorData;
        end
    end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the loop and transition-offset registers.
// Assumes the far-side mirror model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, reset = 1'b1, regWrite = 1'b0, writeAck = 1'b0, backupLoad = 1'b0;
    logic fcc = 1'b0, tStart = 1'b0, mWr, qRate, tAct, tenTab;
    logic [2:0] blk = 3'h0;
    logic [7:0] regAddr = 8'h00, wData = 8'h00, bVal = 8'h00, tgt = 8'h00, cur = 8'h00, rData, mAddr, dacOff;
    logic [1:0] proto = 2'h1;
    logic [2:0] mirr, farSlew;
    ldc_pkg::ldc_rate_e rate = ldc_pkg::RATE_FAST;
    int seed = 32'h217d, nErrors = 0, numChecks = 0, step, expOff, mReg[4] = '{0, 0, 0, 0};
    int mvTab[4] = '{0, 5, 10, 20}, tRate[9] = '{0, 1, 0, 1, 2, 0, 1, 0, 3};
    int tProto[9] = '{1, 0, 3, 2, 1, 1, 1, 0, 2};
    int tCode[9] = '{3, 3, 1, 2, 3, 3, 3, 2, 1}, tBlk[9] = '{0, 0, 0, 0, 0, 1, 2, 4, 0};
    logic [7:0] addrTab[4] = '{8'hAD, 8'hAF, 8'hB0, 8'hB1};
    int slewQ[$];
    always #2 clk = ~clk;
    ldc_config_regs u_ldc_config_regs (.clk(clk), .reset(reset), .regWrite(regWrite), .regAddr(regAddr),
        .regWriteData(wData), .writeAck(writeAck), .regReadData(rData), .backupLoad(backupLoad),
        .backupLoop(bVal), .backupSlew(bVal), .backupOffset(bVal), .vidStepProtocol(proto),
        .forcedContinuousOperation(fcc), .softStartActive(blk[0]), .softStopActive(blk[1]),
        .serialVoutChange(blk[2]), .transitionStart(tStart), .transitionRate(rate), .targetCode(tgt),
        .currentCode(cur), .stepTick(1'b0), .softStartDiscontinuous(), .negOnTimeNumeratorMv(),
        .senseInductanceSelect(), .dcLoadLine(), .fastSlewMirrorWrite(mWr), .fastSlewMirrorAddr(mAddr),
        .fastSlewMirror(mirr), .slewIs10mvTable(tenTab), .dacOffsetCode(dacOff), .quarterRate(qRate),
        .transitionActive(tAct));
    ldc_vid_mirror u_ldc_vid_mirror (.clk(clk), .mirrorWrite(mWr), .mirrorAddr(mAddr), .mirrorData(mirr),
        .fastSlew(farSlew));
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Leaves the request up so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic k);
        regAddr <= a;
        wData <= d;
        regWrite <= 1'b1;
        writeAck <= k;
        @(posedge clk);
        if (k && a == 8'hAD) mReg[0] = d & 8'h7F;
        if (k && a == 8'hAF) mReg[1] = d & 8'h07;
        if (k && a == 8'hAF) slewQ.push_back(d & 8'h07);
        if (k && a == 8'hB0) mReg[2] = d & 8'h0F;
    endtask
    task automatic rdAll;
        regWrite <= 1'b0;
        writeAck <= 1'b0;
        for (int j = 0; j < 4; j++) begin
            regAddr <= addrTab[j];
            @(posedge clk);
            #1 check("readback", 12'(mReg[j]), {4'h0, rData});
        end
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        nErrors++;
        report_and_stop();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rdAll();
        bVal <= 8'hFF;
        backupLoad <= 1'b1;
        @(posedge clk);
        backupLoad <= 1'b0;
        mReg = '{127, 7, 15, 0};
        slewQ.push_back(7);
        rdAll();
        for (int i = 0; i < 40; i++) begin
            proto <= 2'($random(seed));
            fcc <= 1'($random(seed));
            wr(addrTab[2'($random(seed))], 8'($random(seed)), 1'($random(seed)));
            if (i % 4 == 3) rdAll();
        end
        rdAll();
        check("mirror", {9'h000, 3'(slewQ[$])}, {9'h000, farSlew});
        for (int i = 0; i < 9; i++) begin
            step = (tProto[i] == 0 || tProto[i] == 3) ? 10 : 5;
            expOff = (tRate[i] < 2 && tBlk[i] == 0) ? (mvTab[tCode[i]] + step - 1) / step : 0;
            wr(8'hB0, 8'(tCode[i]), 1'b1);
            regWrite <= 1'b0;
            proto <= 2'(tProto[i]);
            rate <= ldc_pkg::ldc_rate_e'(tRate[i]);
            blk <= 3'(tBlk[i]);
            cur <= 8'h40;
            tgt <= 8'h60;
            tStart <= 1'b1;
            @(posedge clk);
            tStart <= 1'b0;
            repeat (2) @(posedge clk);
            #1 check("riseOffset", 12'(expOff), {4'h0, dacOff});
            check("active", 12'(expOff != 0), {11'h000, tAct});
            check("table", 12'(step == 10), {11'h000, tenTab});
            cur <= 8'h60;
            blk <= 3'h0;
            repeat (2) @(posedge clk);
            #1 check("riseDrop", 12'h000, {4'h0, dacOff});
        end
        wr(8'hB0, 8'h0C, 1'b1);
        regWrite <= 1'b0;
        proto <= 2'h1;
        rate <= ldc_pkg::RATE_SLOW;
        tgt <= 8'h40;
        tStart <= 1'b1;
        @(posedge clk);
        tStart <= 1'b0;
        // Fall threshold is target plus four codes
        for (int k = 0; k < 3; k++) begin
            repeat (2) @(posedge clk);
            #1 check("quarterRate", {11'h000, k == 2}, {11'h000, qRate});
            cur <= 8'(8'h5F - 8'(k * 27));
        end
        cur <= 8'h40;
        repeat (3) @(posedge clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
